// file: gtc_channel.v
// Purpose: One 16-bit up-counting timer channel with bus registers
// Assumes: sys_clk is the peripheral clock; ten instances make the block
// Notes:   Read data stand one cycle after the read strobe
// Functional notes
// - Ten identical channels, each a 16-bit up-counter with its own base.
// - Mode field: 00 periodic, 01 PWM, 10 one-shot, 11 capture.
// - Clock select: pclk/2,/4,/16,/64, external clock, or capture pin (pclk/2 instead in capture mode).
// - Capture clear on rising, falling, both edges, or never.
// - Compare writes apply at period end, or at once if immediate update.
// - Output idles high or low by idle level; invert bit flips it.
// - Start-sync channels start together on the shared start event.
// - Clear-sync channels clear their counters together.
// - Converter trigger only while its enable bit is one.
// - Periodic and PWM count 0 to period value minus one.
// - Period-match interrupt only in PWM and one-shot modes.
// - Duty compare drives the output; period end returns it to idle in PWM and one-shot.
// - Capture stores count on the edge matching the clear selection.
// - Status bit 2 duty match, bit 1 period match, sticky until cleared.
// - Counter does not run while period value is zero.
// - Periodic mode toggles output on duty match; zero duty keeps level.
// - Captured count is taken five clocks after the qualifying edge.
// - A flag interrupts only when its enable bit is one.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "gtc_map.vh"
module gtc_channel #(
	parameter PRS_W = 10,  // Prescaler width
	parameter CNT_W = 16   // Counter width
) (
	input  wire             sys_clk,        // Peripheral clock
	input  wire             arst_n,         // Async reset, active low
	input  wire [4:0]       bus_addr,       // Byte offset in channel
	input  wire [31:0]      bus_wdata,      // Write data
	input  wire             bus_wr,         // Write strobe
	input  wire             bus_rd,         // Read strobe
	output reg  [31:0]      bus_rdata,      // Read data, cycle after strobe
	input  wire             clock_capture_pin, // External clock / capture
	input  wire             external_timer_clock, // Alternate clock source
	input  wire             sync_start_in,  // Shared start event
	input  wire             sync_clear_in,  // Shared clear event
	output reg              sync_start_out, // This channel started
	output reg              sync_clear_out, // This channel period cleared
	output reg              timer_output_pin, // Timer output
	output reg              conv_trigger,   // Converter trigger pulse
	output reg              irq             // Channel interrupt
);
	reg [15:0]               ctrl1_r;      // Control one
	reg                      run_r;        // Run command
	reg                      clr_cmd_r;    // One-cycle clear command
	reg [PRS_W-1:0]          prs_r;        // Prescale value
	reg [CNT_W-1:0]          duty_r;       // Duty compare as written
	reg [CNT_W-1:0]          period_r;     // Period compare as written
	reg [CNT_W-1:0]          duty_buf_r;   // Duty compare in use
	reg [CNT_W-1:0]          period_buf_r; // Period compare in use
	reg [CNT_W-1:0]          cnt_r;        // Up-counter
	reg [2:0]                flags_r;      // Duty, period, wrap flags
	reg [2:0]                irqen_r;      // Interrupt enables
	reg [1:0]                pin_sync_r;   // Capture pin synchroniser
	reg [1:0]                ext_sync_r;   // Alternate clock synchroniser
	reg                      pin_d_r;      // Capture pin, one clock on
	reg                      ext_d_r;      // Alternate clock, one on
	reg [5:0]                pdiv_r;       // Free divider of sys_clk
	reg [PRS_W-1:0]          pcnt_r;       // Prescale counter
	reg                      out_lvl_r;    // Output level before invert
	reg [`GTC_CAP_DELAY-1:0] rise_dly_r;   // Rising edges in flight
	reg [`GTC_CAP_DELAY-1:0] fall_dly_r;   // Falling edges in flight
	reg [2:0]                trg_cnt_r;    // Trigger clocks left
	reg [31:0]               rd_mux;       // Read data before its flop

	wire [1:0] mode   = ctrl1_r[`GTC_F_MODE_HI:`GTC_F_MODE_LO];
	wire [2:0] count_clock_select  = ctrl1_r[`GTC_F_COUNT_CLOCK_SELECT_HI:`GTC_F_COUNT_CLOCK_SELECT_LO];
	wire [1:0] clrsel = ctrl1_r[`GTC_F_CLR_HI:`GTC_F_CLR_LO];
	wire       imm    = ctrl1_r[`GTC_B_IMM_UPD];
	wire       cap    = (mode == `GTC_MODE_CAPTURE);
	wire       wr_c1  = bus_wr && bus_addr == `GTC_OFS_CTRL1;
	wire       wr_c2  = bus_wr && bus_addr == `GTC_OFS_CTRL2;
	wire       wr_cnt = bus_wr && bus_addr == `GTC_OFS_COUNT;
	wire       wr_fl  = bus_wr && bus_addr == `GTC_OFS_FLAGS;
	wire       wr_prs = bus_wr && bus_addr == `GTC_OFS_TICKDIV;
	wire       wr_duty = bus_wr && bus_addr == `GTC_OFS_DUTY;
	wire       wr_per = bus_wr && bus_addr == `GTC_OFS_PERIOD;
	wire       wr_ien = bus_wr && bus_addr == `GTC_OFS_IRQEN;
	wire       pin_rise = pin_sync_r[1] & ~pin_d_r;
	wire       pin_fall = ~pin_sync_r[1] & pin_d_r;
	wire       ext_rise = ext_sync_r[1] & ~ext_d_r;

	// Source clock enable; pclk divisions from one free counter
	reg src_en;
	always @* begin
		case (count_clock_select)
		`GTC_CK_DIV2:  src_en = pdiv_r[0];
		`GTC_CK_DIV4:  src_en = &pdiv_r[1:0];
		`GTC_CK_DIV16: src_en = &pdiv_r[3:0];
		`GTC_CK_DIV64: src_en = &pdiv_r[5:0];
		`GTC_CK_EXT_A, `GTC_CK_EXT_B:
			src_en = ext_rise;
		default:       src_en = cap ? pdiv_r[0] : pin_rise;
		endcase
	end

	wire tick = src_en && (pcnt_r == prs_r);
	// Start needs a nonzero period; sync channels also run on shared start
	wire running = (run_r || (ctrl1_r[`GTC_B_START_SYNC] && sync_start_in))
		&& period_buf_r != {CNT_W{1'b0}};
	wire last = (cnt_r == period_buf_r - 1'b1);
	wire per_end = running && tick && !cap && last;
	wire duty_hit = running && tick && !cap && duty_buf_r != 0 &&
		(cnt_r + 1'b1 == duty_buf_r ||
		 (duty_buf_r == period_buf_r && last));
	wire cap_r = rise_dly_r[`GTC_CAP_DELAY-1];
	wire cap_f = fall_dly_r[`GTC_CAP_DELAY-1];
	wire cap_ev = cap && ((cap_r && (clrsel == `GTC_CLR_RISE ||
		clrsel == `GTC_CLR_BOTH)) || (cap_f && (clrsel == `GTC_CLR_FALL ||
		clrsel == `GTC_CLR_BOTH)));
	wire sync_clr = ctrl1_r[`GTC_B_CLEAR_SYNC] && sync_clear_in;
	wire wrap = running && tick && cnt_r == {CNT_W{1'b1}};
	wire idle = ctrl1_r[`GTC_B_IDLE_LVL] ? 1'b0 : 1'b1;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_sync_r <= 2'h0;
			ext_sync_r <= 2'h0;
			pin_d_r    <= 1'b0;
			ext_d_r    <= 1'b0;
			pdiv_r     <= 6'h00;
			pcnt_r     <= {PRS_W{1'b0}};
			rise_dly_r <= {`GTC_CAP_DELAY{1'b0}};
			fall_dly_r <= {`GTC_CAP_DELAY{1'b0}};
		end else begin
			pin_sync_r <= {pin_sync_r[0], clock_capture_pin};
			ext_sync_r <= {ext_sync_r[0], external_timer_clock};
			pin_d_r    <= pin_sync_r[1];
			ext_d_r    <= ext_sync_r[1];
			pdiv_r     <= pdiv_r + 6'h01;
			if (src_en)
				pcnt_r <= (pcnt_r == prs_r) ? {PRS_W{1'b0}} :
					pcnt_r + 1'b1;
			// Edge carried through a short line of flops
			rise_dly_r <= {rise_dly_r[`GTC_CAP_DELAY-2:0], pin_rise};
			fall_dly_r <= {fall_dly_r[`GTC_CAP_DELAY-2:0], pin_fall};
		end
	end

	// Control register and the run and clear commands
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl1_r   <= 16'h0000;
			run_r     <= 1'b0;
			clr_cmd_r <= 1'b0;
		end else begin
			// Clear lives one cycle so a later strobe cannot replay it
			clr_cmd_r <= wr_c2 && bus_wdata[`GTC_B_CLR];
			if (wr_c1)
				ctrl1_r <= bus_wdata[15:0];
			if (wr_c2)
				run_r <= bus_wdata[`GTC_B_RUN];
			else if (per_end && mode == `GTC_MODE_ONESHOT)
				run_r <= 1'b0;
		end
	end

	// Settings written by software
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prs_r    <= {PRS_W{1'b0}};
			duty_r   <= {CNT_W{1'b0}};
			period_r <= {CNT_W{1'b0}};
			irqen_r  <= 3'h0;
		end else begin
			if (wr_prs)
				prs_r <= bus_wdata[PRS_W-1:0];
			if (wr_duty)
				duty_r <= bus_wdata[CNT_W-1:0];
			if (wr_per)
				period_r <= bus_wdata[CNT_W-1:0];
			if (wr_ien)
				irqen_r <= bus_wdata[2:0];
		end
	end

	// Compare buffers load on clear, period end, or at once
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_buf_r   <= {CNT_W{1'b0}};
			period_buf_r <= {CNT_W{1'b0}};
		end else if (imm || clr_cmd_r || per_end) begin
			duty_buf_r   <= duty_r;
			period_buf_r <= period_r;
		end
	end

	// Clear select none matches no edge, so nothing is captured or cleared
	wire cap_clr = cap_ev && clrsel != `GTC_CLR_NONE;

	// Counter: clears beat a software write, which beats counting
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= {CNT_W{1'b0}};
		end else if (clr_cmd_r || sync_clr || cap_clr) begin
			cnt_r <= {CNT_W{1'b0}};
		end else if (wr_cnt) begin
			cnt_r <= bus_wdata[CNT_W-1:0];
		end else if (per_end) begin
			cnt_r <= {CNT_W{1'b0}};
		end else if (running && tick) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	wire       per_flag  = per_end && (mode == `GTC_MODE_PWM ||
		mode == `GTC_MODE_ONESHOT);
	wire [2:0] flag_set  = {duty_hit, per_flag, wrap};
	wire [2:0] flag_keep = wr_fl ? flags_r & ~bus_wdata[2:0] : flags_r;

	// Hardware set beats a write-one clear in the same cycle
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			flags_r <= 3'h0;
		else
			flags_r <= flag_keep | flag_set;
	end

	wire [CNT_W-1:0] cap_val = cnt_r;
	reg  [CNT_W-1:0] cap_r16;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			cap_r16 <= {CNT_W{1'b0}};
		else if (cap_ev)
			cap_r16 <= cap_val;
	end

	// Output level machine
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_lvl_r <= 1'b1;
		end else if (!running || clr_cmd_r) begin
			out_lvl_r <= idle;
		end else if (mode == `GTC_MODE_PERIODIC) begin
			if (duty_hit)
				out_lvl_r <= ~out_lvl_r;
		end else if (mode != `GTC_MODE_CAPTURE) begin
			// Active after duty match until period end
			if (per_end)
				out_lvl_r <= idle;
			else if (duty_hit)
				out_lvl_r <= ~idle;
		end
	end

	// Outputs, all registered
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata        <= 32'h0000_0000;
			timer_output_pin <= 1'b1;
			conv_trigger     <= 1'b0;
			trg_cnt_r        <= 3'h0;
			irq              <= 1'b0;
			sync_start_out   <= 1'b0;
			sync_clear_out   <= 1'b0;
		end else begin
			timer_output_pin <= out_lvl_r ^ ctrl1_r[`GTC_B_OUT_INV];
			irq <= |(flags_r & irqen_r);
			sync_start_out <= run_r && ctrl1_r[`GTC_B_START_SYNC];
			sync_clear_out <= per_end && ctrl1_r[`GTC_B_CLEAR_SYNC];
			// Trigger holds four clocks, then drops by itself
			if (duty_hit && ctrl1_r[`GTC_B_CONV_TRG])
				trg_cnt_r <= `GTC_TRG_LEN;
			else if (trg_cnt_r != 3'h0)
				trg_cnt_r <= trg_cnt_r - 3'h1;
			conv_trigger <= ctrl1_r[`GTC_B_CONV_TRG] &&
				(trg_cnt_r != 3'h0 || duty_hit);
			// Data stand only in the cycle after the strobe
			bus_rdata <= bus_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (bus_addr)
		`GTC_OFS_CTRL1:   rd_mux = {16'h0000, ctrl1_r};
		`GTC_OFS_CTRL2:   rd_mux = {31'h0, run_r};
		`GTC_OFS_TICKDIV: rd_mux = {{(32-PRS_W){1'b0}}, prs_r};
		`GTC_OFS_DUTY:    rd_mux = {{(32-CNT_W){1'b0}}, duty_r};
		`GTC_OFS_PERIOD:  rd_mux = cap ?
			{{(32-CNT_W){1'b0}}, cap_r16} :
			{{(32-CNT_W){1'b0}}, period_r};
		`GTC_OFS_COUNT:   rd_mux = {{(32-CNT_W){1'b0}}, cnt_r};
		`GTC_OFS_FLAGS:   rd_mux = {29'h0, flags_r};
		`GTC_OFS_IRQEN:   rd_mux = {29'h0, irqen_r};
		default:          rd_mux = 32'h0000_0000;
		endcase
	end
endmodule // gtc_channel

// file: gtc_channel_sva.sv
// Purpose: Port checks for one timer channel
// Assumes: Shadow copies follow writes on the register port
// Notes:   Bound to every gtc_channel
`timescale 1ns/100ps
`include "gtc_map.vh"
module gtc_channel_sva (
	input wire        sys_clk,          // Clock
	input wire        arst_n,           // Reset, active low
	input wire [4:0]  bus_addr,         // Offset
	input wire [31:0] bus_wdata,        // Write data
	input wire        bus_wr,           // Write strobe
	input wire        bus_rd,           // Read strobe
	input wire [31:0] bus_rdata,        // Read data
	input wire        sync_start_out,   // Start event
	input wire        sync_clear_out,   // Clear event
	input wire        timer_output_pin, // Output pin
	input wire        conv_trigger,     // Converter trigger
	input wire        irq               // Interrupt
);
	reg [15:0] c1_r, per_r;
	reg [7:0]  ien_r;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			c1_r <= 16'h0;
			per_r <= 16'h0;
			ien_r <= 8'h0;
		end else if (bus_wr) begin
			if (bus_addr == `GTC_OFS_CTRL1) c1_r <= bus_wdata[15:0];
			if (bus_addr == `GTC_OFS_PERIOD) per_r <= bus_wdata[15:0];
			if (bus_addr == `GTC_OFS_IRQEN) ien_r <= bus_wdata[7:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_trig_rise; $rose(conv_trigger); endsequence
	sequence s_trig_hold; conv_trigger [*3] ##[1:2] !conv_trigger; endsequence
	a_trig_len: assert property (s_trig_rise |-> s_trig_hold)
		else $error("trigger pulse length");
	a_trig_gate: assert property (s_trig_rise |-> $past(c1_r[8]))
		else $error("trigger while disabled");
	a_rd_ctrl: assert property (bus_rd && bus_addr == `GTC_OFS_CTRL1
		|=> bus_rdata == {16'h0, c1_r}) else $error("control readback");
	a_irq_mask: assert property ((ien_r == 8'h0) [*3] |-> !irq)
		else $error("masked interrupt");
	a_irq_cause: assert property ($rose(irq) |-> ien_r != 8'h0)
		else $error("interrupt without enable");
	a_start_gate: assert property (!c1_r[15] [*3] |-> !sync_start_out)
		else $error("start event while unsynced");
	a_clear_gate: assert property (sync_clear_out |-> $past(c1_r[14]))
		else $error("clear event while unsynced");
	a_zero_hold: assert property ((per_r == 16'h0 && $stable(c1_r)) [*3]
		|-> $stable(timer_output_pin)) else $error("ran with zero period");
endmodule // gtc_channel_sva
bind gtc_channel gtc_channel_sva gtc_channel_sva_i (.sys_clk, .arst_n,
	.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .sync_start_out,
	.sync_clear_out, .timer_output_pin, .conv_trigger, .irq);

// file: gtc_channel_test.sv
// Purpose: Self-checking bench for one timer channel
// Assumes: Pin model drives the capture and alternate clock inputs
// Notes:   Sync inputs held low, so the channel runs alone
`timescale 1ns/100ps
`include "gtc_map.vh"
module gtc_channel_test;
	reg         sys_clk = 1'b0;
	reg         arst_n = 1'b0;
	reg  [4:0]  bus_addr = 5'h0;
	reg  [31:0] bus_wdata = 32'h0;
	reg         bus_wr = 1'b0;
	reg         bus_rd = 1'b0;
	reg         fire = 1'b0;
	reg         trig_seen = 1'b0;
	reg         scl_seen = 1'b0;
	reg         p;
	reg  [31:0] d;
	wire [31:0] bus_rdata;
	wire        cap_pin, ext_clk, sso, scl, pin, trig, irq;
	integer     miscompares = 0;
	integer     checks = 0;
	integer     i, n;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (trig) trig_seen <= 1'b1;
	always @(posedge sys_clk) if (scl) scl_seen <= 1'b1;
	gtc_pin_side gtc_pin_side_i (.sys_clk(sys_clk), .fire(fire),
		.clock_capture_pin(cap_pin), .external_timer_clock(ext_clk));
	gtc_channel gtc_channel_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .clock_capture_pin(cap_pin),
		.external_timer_clock(ext_clk), .sync_start_in(1'b0),
		.sync_clear_in(1'b0), .sync_start_out(sso), .sync_clear_out(scl),
		.timer_output_pin(pin), .conv_trigger(trig), .irq(irq));
	task wr(input [4:0] a, input [15:0] v);
		begin
			bus_addr <= a;
			bus_wdata <= {16'h0, v};
			bus_wr <= 1'b1;
			@(posedge sys_clk);
			bus_wr <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	task rd(input [4:0] a);
		begin
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge sys_clk);
			bus_rd <= 1'b0;
			#1 d = bus_rdata;
			@(posedge sys_clk);
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("MISMATCH %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task toggles;
		begin
			n = 0;
			#1 p = pin;
			repeat (16) begin
				@(posedge sys_clk);
				#1 if (pin !== p) n = n + 1;
				p = pin;
			end
			@(posedge sys_clk);
		end
	endtask
	task t_reset;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				rd({i[2:0], 2'h0});
				chk(d, 32'h0);
			end
			rd(5'h02);
			chk(d, 32'h0);
			chk(pin, 32'h1);
			wr(`GTC_OFS_CTRL2, 16'h3);
			repeat (20) @(posedge sys_clk);
			rd(`GTC_OFS_COUNT);
			chk(d, 32'h0);
			wr(`GTC_OFS_CTRL2, 16'h0);
			$display("reset test done");
		end
	endtask
	task t_clocks;
		begin
			wr(`GTC_OFS_PERIOD, 16'hffff);
			for (i = 0; i < 7; i = i + 1) begin
				wr(`GTC_OFS_CTRL1, {9'h100, i[2:0], 4'h1});
				wr(`GTC_OFS_CTRL2, 16'h3);
				repeat (150) @(posedge sys_clk);
				rd(`GTC_OFS_COUNT);
				chk(d != 32'h0, i < 6);
				chk(sso, 32'h1);
				wr(`GTC_OFS_CTRL2, 16'h0);
			end
			wr(`GTC_OFS_CTRL1, 16'h1);
			wr(`GTC_OFS_TICKDIV, 16'h3);
			wr(`GTC_OFS_CTRL2, 16'h3);
			repeat (80) @(posedge sys_clk);
			rd(`GTC_OFS_COUNT);
			chk(d >= 32'h8 && d <= 32'hc, 32'h1);
			wr(`GTC_OFS_CTRL2, 16'h0);
			wr(`GTC_OFS_TICKDIV, 16'h0);
			$display("clock test done");
		end
	endtask
	task t_periodic;
		begin
			wr(`GTC_OFS_PERIOD, 16'h4);
			wr(`GTC_OFS_DUTY, 16'h2);
			wr(`GTC_OFS_CTRL1, 16'h4000);
			wr(`GTC_OFS_CTRL2, 16'h3);
			for (i = 0; i < 6; i = i + 1) begin
				rd(`GTC_OFS_COUNT);
				chk(d < 32'h4, 32'h1);
			end
			rd(`GTC_OFS_FLAGS);
			chk(d[2], 32'h1);
			chk(scl_seen, 32'h1);
			toggles;
			chk(n, 32'h2);
			wr(`GTC_OFS_CTRL1, 16'h6000);
			wr(`GTC_OFS_DUTY, 16'h0);
			repeat (10) @(posedge sys_clk);
			toggles;
			chk(n, 32'h0);
			$display("periodic test done");
		end
	endtask
	task t_irq;
		begin
			wr(`GTC_OFS_IRQEN, 16'h4);
			repeat (3) @(posedge sys_clk);
			chk(irq, 32'h1);
			wr(`GTC_OFS_IRQEN, 16'h0);
			repeat (2) @(posedge sys_clk);
			chk(irq, 32'h0);
			wr(`GTC_OFS_CTRL2, 16'h0);
			wr(`GTC_OFS_FLAGS, 16'h7);
			rd(`GTC_OFS_FLAGS);
			chk(d, 32'h0);
			wr(`GTC_OFS_IRQEN, 16'h7);
			repeat (2) @(posedge sys_clk);
			chk(irq, 32'h0);
			wr(`GTC_OFS_CTRL1, 16'h1000);
			repeat (2) @(posedge sys_clk);
			chk(pin, 32'h0);
			$display("interrupt test done");
		end
	endtask
	task t_oneshot;
		begin
			wr(`GTC_OFS_DUTY, 16'h2);
			wr(`GTC_OFS_PERIOD, 16'h6);
			wr(`GTC_OFS_CTRL1, 16'h0102);
			wr(`GTC_OFS_CTRL2, 16'h3);
			repeat (60) @(posedge sys_clk);
			rd(`GTC_OFS_CTRL2);
			chk(d, 32'h0);
			rd(`GTC_OFS_FLAGS);
			chk(d[2:1], 32'h3);
			chk(trig_seen, 32'h1);
			$display("one-shot test done");
		end
	endtask
	task t_capture;
		begin
			wr(`GTC_OFS_PERIOD, 16'hffff);
			wr(`GTC_OFS_CTRL1, 16'h0003);
			wr(`GTC_OFS_CTRL2, 16'h3);
			repeat (60) @(posedge sys_clk);
			fire <= 1'b1;
			@(posedge sys_clk);
			fire <= 1'b0;
			repeat (30) @(posedge sys_clk);
			rd(`GTC_OFS_PERIOD);
			chk(d != 32'h0 && d < 32'h40, 32'h1);
			$display("capture test done");
		end
	endtask
	task conclude;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// About three times the expected run length
	initial begin
		#20000;
		miscompares = miscompares + 1;
		conclude;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_clocks;
		t_periodic;
		t_irq;
		t_oneshot;
		t_capture;
		conclude;
	end
endmodule // gtc_channel_test

// file: gtc_map.vh
// Purpose: Register map, field positions and codes for one timer channel
// Assumes: Included by the channel, its checker and its bench
// Notes:   Definitions only
`ifndef GTC_MAP_VH
`define GTC_MAP_VH
`define GTC_OFS_CTRL1      5'h00
`define GTC_OFS_CTRL2      5'h04
`define GTC_OFS_TICKDIV    5'h08
`define GTC_OFS_DUTY       5'h0c
`define GTC_OFS_PERIOD     5'h10
`define GTC_OFS_COUNT      5'h14
`define GTC_OFS_FLAGS      5'h18
`define GTC_OFS_IRQEN      5'h1c
`define GTC_B_START_SYNC   15
`define GTC_B_CLEAR_SYNC   14
`define GTC_B_IMM_UPD      13
`define GTC_B_OUT_INV      12
`define GTC_B_CONV_TRG     8
`define GTC_B_IDLE_LVL     7
`define GTC_F_COUNT_CLOCK_SELECT_HI     6
`define GTC_F_COUNT_CLOCK_SELECT_LO     4
`define GTC_F_CLR_HI       3
`define GTC_F_CLR_LO       2
`define GTC_F_MODE_HI      1
`define GTC_F_MODE_LO      0
`define GTC_B_RUN          0
`define GTC_B_CLR          1
`define GTC_B_DUTY_FLAG    2
`define GTC_B_PER_FLAG     1
`define GTC_B_WRAP_FLAG    0
`define GTC_MODE_PERIODIC  2'h0
`define GTC_MODE_PWM       2'h1
`define GTC_MODE_ONESHOT   2'h2
`define GTC_MODE_CAPTURE   2'h3
`define GTC_CLR_RISE       2'h0
`define GTC_CLR_FALL       2'h1
`define GTC_CLR_BOTH       2'h2
`define GTC_CLR_NONE       2'h3
`define GTC_CK_EXT_A       3'h4
`define GTC_CK_EXT_B       3'h5
`define GTC_CK_DIV2        3'h0
`define GTC_CK_DIV4        3'h1
`define GTC_CK_DIV16       3'h2
`define GTC_CK_DIV64       3'h3
`define GTC_CAP_DELAY      5
`define GTC_TRG_LEN        3'h3
`endif

// file: gtc_pin_side.sv
// Purpose: Far-side model of the capture and alternate clock pins
// Assumes: Capture pulse is launched off the bench clock
// Notes:   Alternate clock runs free, one edge every 16 cycles
`timescale 1ns/100ps
module gtc_pin_side (
	input  wire sys_clk,             // Bench clock
	input  wire fire,                // Request one capture pulse
	output reg  clock_capture_pin,   // Capture input, low when quiet
	output reg  external_timer_clock // Free-running alternate clock
);
	reg [3:0] div_r = 4'h0;
	initial clock_capture_pin = 1'b0;
	initial external_timer_clock = 1'b0;
	always @(posedge sys_clk) begin
		div_r <= div_r + 4'h1;
		if (div_r == 4'hf)
			external_timer_clock <= ~external_timer_clock;
	end
	// Long pulse so the synchroniser cannot miss it
	always @(posedge fire) begin
		@(posedge sys_clk);
		clock_capture_pin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		clock_capture_pin <= 1'b0;
	end
endmodule // gtc_pin_side
